// ### core/tcfr_core.v
// i2c slave, conversion control and sample fifo of the temperature readout
`timescale 1ns/10ps
`include "tcfr_map.vh"

// Overview of operation
// - reset leaves converter idle in standby
// - writing convert bit starts conversion
// - low convert pin starts conversion when configured
// - finished result pushed, then back to standby
// - fifo holds 32 two-byte results
// - msb first, 16-bit two's complement word
// - one count equals 0.005 degrees
// - top bit is the sign
// - pins sampled at start form address bits
// - interrupt pin signals enabled status flags in mode 11
// - host reaches thresholds and setup register
// - thresholds and setup reset to defaults
// - convert pin triggers only in mode 11
// - modes 01 and 11 force address bit zero
module tcfr_core #(
   parameter CONV_CYCLES = `TCFR_CONV_TIME_NS / `TCFR_CLK_PERIOD_NS,
   parameter CNT_W = 20,
   parameter FIFO_DEPTH = 32,
   parameter FIFO_AW = 5
) (
   // clock and reset
   input wire ref_clk_in,
   input wire srst_in,
   // i2c pins
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe_out,
   // general pins
   input wire interrupt_capable_pin_in,
   output wire interrupt_capable_pin_out,
   output reg interrupt_capable_pin_oe_out,
   input wire convert_capable_pin_in,
   output wire convert_capable_pin_out,
   output wire convert_capable_pin_oe_out,
   // sensor front end
   input wire [15:0] temp_code_in,
   output reg conv_busy_out
);
   localparam S_IDLE = 5'h01;
   localparam S_RX = 5'h02;
   localparam S_ACK = 5'h04;
   localparam S_TX = 5'h08;
   localparam S_MACK = 5'h10;

   // pin synchronisers, stage one feeds stage two only
   reg scl_s1_r, scl_s2_r, scl_d_r;
   reg sda_s1_r, sda_s2_r, sda_d_r;
   reg gp0_s1_r, gp0_s2_r, gp1_s1_r, gp1_s2_r;
   always @(posedge ref_clk_in) begin
      scl_s1_r <= scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_in;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      gp0_s1_r <= interrupt_capable_pin_in;
      gp0_s2_r <= gp0_s1_r;
      gp1_s1_r <= convert_capable_pin_in;
      gp1_s2_r <= gp1_s1_r;
   end

   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // registers
   reg [15:0] high_threshold_r;
   reg [15:0] low_threshold_r;
   reg [7:0] setup_r;
   reg [7:0] int_en_r;
   reg [7:0] gpio_setup_r;
   wire [1:0] int_mode = gpio_setup_r[`TCFR_INTERRUPT_PIN_MODE_FIELD];
   wire [1:0] conv_mode = gpio_setup_r[`TCFR_CONVERT_PIN_MODE_FIELD];

   // fifo
   wire fifo_empty, fifo_full;
   wire [15:0] fifo_rdata;
   reg fifo_push_r, fifo_pop_r;
   reg [15:0] fifo_wdata_r;
   tcfr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .srst_in(srst_in),
      .push_in(fifo_push_r),
      .wdata_in(fifo_wdata_r),
      .pop_in(fifo_pop_r),
      .rdata_out(fifo_rdata),
      .empty_out(fifo_empty),
      .full_out(fifo_full)
   );

   wire [7:0] status = {5'h00, conv_busy_out, fifo_full, ~fifo_empty};

   // i2c slave state
   reg [4:0] state_r;
   reg [7:0] shreg_r;
   reg [7:0] txsh_r;
   reg [3:0] bitcnt_r;
   reg [1:0] byte_idx_r;
   reg rw_r;
   reg nack_r;
   reg [7:0] ptr_r;
   reg [1:0] addr_lo_r;
   reg byte_hi_r;
   reg conv_wr_r;

   // read mux for every byte-wide view except the fifo word
   reg [7:0] rd_byte;
   always @* begin
      case (ptr_r)
         `TCFR_REG_STATUS: rd_byte = status;
         `TCFR_REG_INT_EN: rd_byte = int_en_r;
         `TCFR_REG_HI_MSB: rd_byte = high_threshold_r[15:8];
         `TCFR_REG_HI_LSB: rd_byte = high_threshold_r[7:0];
         `TCFR_REG_LO_MSB: rd_byte = low_threshold_r[15:8];
         `TCFR_REG_LO_LSB: rd_byte = low_threshold_r[7:0];
         `TCFR_REG_SETUP: rd_byte = {setup_r[7:1], conv_busy_out};
         `TCFR_REG_GPIO: rd_byte = gpio_setup_r;
         default: rd_byte = 8'h00;
      endcase
   end

   // byte loader for transmit; the fifo word goes high byte first
   reg [7:0] tx_byte;
   reg tx_pop;
   always @* begin
      tx_pop = 1'b0;
      if (ptr_r == `TCFR_REG_FIFO_DATA) begin
         tx_byte = byte_hi_r ? fifo_rdata[15:8] : fifo_rdata[7:0];
         tx_pop = ~byte_hi_r;
      end else begin
         tx_byte = rd_byte;
      end
   end

   // i2c protocol engine and register writes
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_r <= S_IDLE;
         shreg_r <= 8'h00;
         txsh_r <= 8'h00;
         bitcnt_r <= 4'h0;
         byte_idx_r <= 2'h0;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
         ptr_r <= 8'h00;
         addr_lo_r <= 2'h0;
         byte_hi_r <= 1'b1;
         fifo_pop_r <= 1'b0;
         conv_wr_r <= 1'b0;
         high_threshold_r <= `TCFR_HI_RST;
         low_threshold_r <= `TCFR_LO_RST;
         setup_r <= `TCFR_SETUP_RST;
         int_en_r <= `TCFR_INT_EN_RST;
         gpio_setup_r <= `TCFR_GPIO_RST;
      end else begin
         fifo_pop_r <= 1'b0;
         conv_wr_r <= 1'b0;
         if (start_det) begin
            state_r <= S_RX;
            bitcnt_r <= 4'h0;
            byte_idx_r <= 2'h0;
            addr_lo_r[1] <= (conv_mode[0] == 1'b1) ? 1'b0 : gp1_s2_r;
            addr_lo_r[0] <= (int_mode[0] == 1'b1) ? 1'b0 : gp0_s2_r;
         end else if (stop_det) begin
            state_r <= S_IDLE;
         end else begin
            case (state_r)
               S_IDLE: begin
                  bitcnt_r <= 4'h0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     shreg_r <= {shreg_r[6:0], sda_s2_r};
                     bitcnt_r <= bitcnt_r + 1'b1;
                  end else if (scl_fall && bitcnt_r == 4'h8) begin
                     bitcnt_r <= 4'h0;
                     state_r <= S_ACK;
                     if (byte_idx_r == 2'h0) begin
                        rw_r <= shreg_r[0];
                        byte_idx_r <= 2'h1;
                        if (shreg_r[7:1] != {`TCFR_ADDR_BASE, addr_lo_r}) begin
                           state_r <= S_IDLE;
                        end
                     end else if (byte_idx_r == 2'h1) begin
                        ptr_r <= shreg_r;
                        byte_hi_r <= 1'b1;
                        byte_idx_r <= 2'h2;
                     end else begin
                        case (ptr_r)
                           `TCFR_REG_INT_EN: int_en_r <= shreg_r;
                           `TCFR_REG_HI_MSB: high_threshold_r[15:8] <= shreg_r;
                           `TCFR_REG_HI_LSB: high_threshold_r[7:0] <= shreg_r;
                           `TCFR_REG_LO_MSB: low_threshold_r[15:8] <= shreg_r;
                           `TCFR_REG_LO_LSB: low_threshold_r[7:0] <= shreg_r;
                           `TCFR_REG_SETUP: begin
                              setup_r <= {shreg_r[7:1], 1'b0};
                              conv_wr_r <= shreg_r[`TCFR_SETUP_CONV_BIT];
                           end
                           `TCFR_REG_GPIO: gpio_setup_r <= shreg_r;
                           default: ;
                        endcase
                        if (ptr_r != `TCFR_REG_FIFO_DATA) begin
                           ptr_r <= ptr_r + 1'b1;
                        end
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     bitcnt_r <= 4'h0;
                     if (rw_r) begin
                        state_r <= S_TX;
                        txsh_r <= tx_byte;
                        fifo_pop_r <= tx_pop;
                        byte_hi_r <= ~byte_hi_r | (ptr_r != `TCFR_REG_FIFO_DATA);
                        if (ptr_r != `TCFR_REG_FIFO_DATA) begin
                           ptr_r <= ptr_r + 1'b1;
                        end
                     end else begin
                        state_r <= S_RX;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bitcnt_r == 4'h7) begin
                        state_r <= S_MACK;
                     end else begin
                        txsh_r <= {txsh_r[6:0], 1'b0};
                        bitcnt_r <= bitcnt_r + 1'b1;
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise) begin
                     nack_r <= sda_s2_r;
                  end else if (scl_fall) begin
                     if (nack_r) begin
                        state_r <= S_IDLE;
                     end else begin
                        state_r <= S_TX;
                        bitcnt_r <= 4'h0;
                        txsh_r <= tx_byte;
                        fifo_pop_r <= tx_pop;
                        byte_hi_r <= ~byte_hi_r | (ptr_r != `TCFR_REG_FIFO_DATA);
                        if (ptr_r != `TCFR_REG_FIFO_DATA) begin
                           ptr_r <= ptr_r + 1'b1;
                        end
                     end
                  end
               end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // open-drain data line, registered to keep hold time after scl falls
   assign sda_out = 1'b0;
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         sda_oe_out <= 1'b0;
      end else begin
         sda_oe_out <= (state_r == S_ACK) | ((state_r == S_TX) & ~txsh_r[7]);
      end
   end

   // interrupt pin, active low open drain
   assign interrupt_capable_pin_out = 1'b0;
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         interrupt_capable_pin_oe_out <= 1'b0;
      end else begin
         interrupt_capable_pin_oe_out <= (int_mode == `TCFR_MODE_SPECIAL) &
            (|(status & int_en_r));
      end
   end

   // convert pin is input only here
   assign convert_capable_pin_out = 1'b0;
   assign convert_capable_pin_oe_out = 1'b0;

   // external trigger only in mode 11
   wire ext_trig = (conv_mode == `TCFR_MODE_SPECIAL) & ~gp1_s2_r;
   reg [CNT_W-1:0] conv_cnt_r;

   // conversion sequencer; a level trigger held low restarts after each result
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         conv_busy_out <= 1'b0;
         conv_cnt_r <= {CNT_W{1'b0}};
         fifo_push_r <= 1'b0;
         fifo_wdata_r <= 16'h0000;
      end else begin
         fifo_push_r <= 1'b0;
         if (!conv_busy_out) begin
            if (conv_wr_r | ext_trig) begin
               conv_busy_out <= 1'b1;
               conv_cnt_r <= CONV_CYCLES[CNT_W-1:0] - 1'b1;
            end
         end else if (conv_cnt_r == {CNT_W{1'b0}}) begin
            conv_busy_out <= 1'b0;
            fifo_push_r <= 1'b1;
            fifo_wdata_r <= temp_code_in;
         end else begin
            conv_cnt_r <= conv_cnt_r - 1'b1;
         end
      end
   end
endmodule

// ### core/tcfr_fifo.v
// sample fifo storage with registered read data
`timescale 1ns/10ps
module tcfr_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // clock and reset
   input wire ref_clk_in,
   input wire srst_in,
   // write side
   input wire push_in,
   input wire [WIDTH-1:0] wdata_in,
   // read side
   input wire pop_in,
   output reg [WIDTH-1:0] rdata_out,
   // state
   output wire empty_out,
   output wire full_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire do_push;
   wire do_pop;

   // overflow and underflow are blocked here, not by the caller
   assign empty_out = (count_r == {(AW+1){1'b0}});
   assign full_out = (count_r == DEPTH[AW:0]);
   assign do_push = push_in & ~full_out;
   assign do_pop = pop_in & ~empty_out;

   // storage, no reset needed on the array
   always @(posedge ref_clk_in) begin
      if (do_push) begin
         mem[wr_ptr_r] <= wdata_in;
      end
      rdata_out <= mem[rd_ptr_r];
   end

   // pointers and occupancy
   always @(posedge ref_clk_in) begin
      if (srst_in) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (do_push & ~do_pop) begin
            count_r <= count_r + 1'b1;
         end else if (do_pop & ~do_push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// ### include/tcfr_map.vh
// register map, field positions, reset values and timing for the temperature readout
`ifndef TCFR_MAP_VH
`define TCFR_MAP_VH
// register pointer values
`define TCFR_REG_STATUS 8'h00
`define TCFR_REG_INT_EN 8'h01
`define TCFR_REG_FIFO_DATA 8'h08
`define TCFR_REG_HI_MSB 8'h10
`define TCFR_REG_HI_LSB 8'h11
`define TCFR_REG_LO_MSB 8'h12
`define TCFR_REG_LO_LSB 8'h13
`define TCFR_REG_SETUP 8'h14
`define TCFR_REG_GPIO 8'h20
// reset values
`define TCFR_HI_RST 16'h7fff
`define TCFR_LO_RST 16'h8000
`define TCFR_SETUP_RST 8'h00
`define TCFR_INT_EN_RST 8'h00
`define TCFR_GPIO_RST 8'h0a
// field positions
`define TCFR_SETUP_CONV_BIT 0
`define TCFR_INTERRUPT_PIN_MODE_FIELD 1:0
`define TCFR_CONVERT_PIN_MODE_FIELD 3:2
`define TCFR_ST_NOT_EMPTY 0
`define TCFR_ST_FULL 1
`define TCFR_ST_BUSY 2
// pin mode codes
`define TCFR_MODE_OUTPUT 2'h1
`define TCFR_MODE_SPECIAL 2'h3
// slave address upper five bits
`define TCFR_ADDR_BASE 5'h14
// conversion time and clock period, both in ns
`define TCFR_CONV_TIME_NS 17850000
`define TCFR_CLK_PERIOD_NS 20
`endif

// ### tb/tb_top.sv
// self-checking bench for the temperature readout core
`timescale 1ns/10ps
module tb_top;
   logic ref_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic conv_lvl = 1'b0;
   logic int_lvl = 1'b0;
   logic [15:0] code = 16'h0000;
   wire scl, host_oe, sda_oe, int_oe, busy;
   wire sda = !(sda_oe | host_oe);
   wire int_pin = int_lvl & !int_oe;
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   logic [7:0] got[$];
   logic [15:0] exp_q[$];
   logic k;
   logic [7:0] q;
   always #10 ref_clk_in = !ref_clk_in;
   tcfr_core #(.CONV_CYCLES(400), .CNT_W(20), .FIFO_DEPTH(32), .FIFO_AW(5)) dut (
      .ref_clk_in(ref_clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda), .sda_out(),
      .sda_oe_out(sda_oe), .interrupt_capable_pin_in(int_pin), .interrupt_capable_pin_out(),
      .interrupt_capable_pin_oe_out(int_oe), .convert_capable_pin_in(conv_lvl),
      .convert_capable_pin_out(), .convert_capable_pin_oe_out(), .temp_code_in(code),
      .conv_busy_out(busy));
   tcfr_host host (.scl_out(scl), .sda_oe_out(host_oe), .sda_in(sda));
   function automatic logic [31:0] mdeg(input logic [15:0] w);
      return 32'($signed(w)) * 5;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_in);
      #2;
   endtask
   task automatic ptr(input logic [7:0] p);
      host.start();
      host.byte_io(8'ha0, 1'b1, q, k);
      chk(32'(k), 32'h1);
      host.byte_io(p, 1'b1, q, k);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      ptr(p);
      host.byte_io(d, 1'b1, q, k);
      chk(32'(k), 32'h1);
      host.stop();
      step(1);
   endtask
   task automatic rd(input logic [7:0] p, input int n);
      got.delete();
      ptr(p);
      host.start();
      host.byte_io(8'ha1, 1'b1, q, k);
      for (int i = 0; i < n; i++) begin
         host.byte_io(8'hff, i == n - 1, q, k);
         got.push_back(q);
      end
      host.stop();
      step(1);
   endtask
   task automatic probe(input logic [7:0] a);
      host.start();
      host.byte_io(a, 1'b1, q, k);
      host.stop();
      step(1);
   endtask
   // bounded wait, a hang shows as a mismatch
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 2000) begin
         step(1);
         n++;
      end
      chk(32'(busy), 32'(lvl));
   endtask
   // run ceiling, about twice the expected length
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 50000) begin
         failures++;
         conclude();
      end
   end
   initial begin
      void'($urandom(88));
      step(5);
      srst_in = 1'b0;
      step(100);
      chk(32'(busy), 32'h0);
      rd(8'h10, 5);
      chk({got[0], got[1], got[2], got[3]}, 32'h7fff8000);
      chk(32'(got[4]), 32'h0);
      code = 16'($urandom);
      wr(8'h10, code[15:8]);
      wr(8'h11, code[7:0]);
      rd(8'h10, 2);
      chk(32'({got[0], got[1]}), 32'(code));
      $display("test 1 done");
      // software trigger, a second one while busy, then one word out
      for (int j = 0; j < 2; j++) begin
         code = j ? 16'hf060 : 16'($urandom) | 16'h8000;
         wr(8'h14, 8'h01);
         chk(32'(busy), 32'h1);
         wait_busy(1'b1);
         wr(8'h14, 8'h01);
         wait_busy(1'b0);
         rd(8'h00, 1);
         chk(32'(got[0] & 8'h07), 32'h1);
         rd(8'h08, 2);
         chk(32'({got[0], got[1]}), 32'(code));
         chk(32'(got[0][7]), 32'h1);
         chk(mdeg({got[0], got[1]}), j ? -32'sd20000 : mdeg(code));
         rd(8'h00, 1);
         chk(32'(got[0] & 8'h01), 32'h0);
      end
      $display("test 2 done");
      wr(8'h01, 8'h01);
      wr(8'h20, 8'h0f);
      chk(32'(busy), 32'h1);
      for (int i = 0; i < 34; i++) begin
         wait_busy(1'b1);
         code = 16'($urandom);
         if (i < 32) exp_q.push_back(code);
         if (i == 33) conv_lvl = 1'b1;
         wait_busy(1'b0);
      end
      step(10);
      chk(32'(int_oe), 32'h1);
      int_lvl = 1'b1;
      probe(8'ha6);
      chk(32'(k), 32'h0);
      rd(8'h00, 1);
      chk(32'(got[0] & 8'h07), 32'h3);
      rd(8'h08, 64);
      for (int i = 0; i < 32; i++) begin
         chk(32'({got[2 * i], got[2 * i + 1]}), 32'(exp_q[i]));
         chk(32'(got[2 * i][7]), 32'(exp_q[i][15]));
      end
      rd(8'h00, 1);
      chk(32'(got[0] & 8'h07), 32'h0);
      chk(32'(int_oe), 32'h0);
      $display("test 3 done");
      srst_in = 1'b1;
      step(5);
      srst_in = 1'b0;
      step(10);
      for (int a = 0; a < 4; a++) begin
         {conv_lvl, int_lvl} = 2'(a);
         step(10);
         probe(8'ha0 | 8'(a << 1));
         chk(32'(k), 32'h1);
         probe(8'ha0 | 8'((a ^ 3) << 1));
         chk(32'(k), 32'h0);
      end
      // mode 01 on both pins: no trigger, address bits forced low
      {conv_lvl, int_lvl} = 2'h0;
      step(10);
      wr(8'h20, 8'h05);
      step(10);
      chk(32'(busy), 32'h0);
      {conv_lvl, int_lvl} = 2'h3;
      step(10);
      probe(8'ha6);
      chk(32'(k), 32'h0);
      probe(8'ha0);
      chk(32'(k), 32'h1);
      $display("test 4 done");
      conclude();
   end
endmodule

// ### tb/tcfr_host.sv
// i2c host controller model, scl stands high between frames
`timescale 1ns/10ps
module tcfr_host (
   // bus lines
   output logic scl_out,
   output logic sda_oe_out,
   input wire sda_in
);
   // released bus at start
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end
   // data moves a third into the low phase, well clear of the device's own answer
   task automatic bit_io(input logic b, output logic r);
      #40 sda_oe_out = !b;
      #80 scl_out = 1'b1;
      #40 r = sda_in;
      scl_out = 1'b0;
   endtask
   task automatic start();
      #40 sda_oe_out = 1'b0;
      #80 scl_out = 1'b1;
      #100 sda_oe_out = 1'b1;
      #100 scl_out = 1'b0;
   endtask
   task automatic stop();
      #40 sda_oe_out = 1'b1;
      #80 scl_out = 1'b1;
      #100 sda_oe_out = 1'b0;
      #100;
   endtask
   // eight bits msb first, ninth bit driven as nine (1 releases)
   task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q,
                          output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(nine, r);
      ack = !r;
   endtask
endmodule

// ### tb/tcfr_properties.sv
// pin-level checks for the temperature readout core
`timescale 1ns/10ps
module tcfr_properties #(
   parameter CONV_CYCLES = 892500,
   parameter CNT_W = 20
) (
   // clock and reset
   input wire ref_clk_in,
   input wire srst_in,
   // i2c pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe_out,
   // general pins
   input wire interrupt_capable_pin_in,
   input wire interrupt_capable_pin_out,
   input wire interrupt_capable_pin_oe_out,
   input wire convert_capable_pin_in,
   input wire convert_capable_pin_out,
   input wire convert_capable_pin_oe_out,
   // front end
   input wire [15:0] temp_code_in,
   input wire conv_busy_out
);
   localparam [CNT_W-1:0] BUSY_LEN = CONV_CYCLES;
   reg [CNT_W-1:0] busy_len_r;
   reg [7:0] age_r;
   reg scl_q_r;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);
   // busy length, and cycles since an scl fall or a low convert pin
   always @(posedge ref_clk_in) begin
      scl_q_r <= scl_in;
      busy_len_r <= (srst_in || !conv_busy_out) ? {CNT_W{1'b0}} : busy_len_r + 1'b1;
      if (srst_in || !convert_capable_pin_in || (scl_q_r && !scl_in)) begin
         age_r <= 8'h00;
      end else if (age_r != 8'hff) begin
         age_r <= age_r + 8'h01;
      end
   end
   chk_reset_quiet: assert property (
      $fell(srst_in) |-> !conv_busy_out && !sda_oe_out && !interrupt_capable_pin_oe_out)
      else $error("outputs active after reset");
   chk_busy_length: assert property (
      $fell(conv_busy_out) |-> busy_len_r == BUSY_LEN)
      else $error("conversion length off");
   chk_busy_min: assert property (
      $rose(conv_busy_out) |-> conv_busy_out [*8])
      else $error("conversion cut short");
   chk_trigger_cause: assert property (
      $rose(conv_busy_out) |-> age_r <= 8'h08)
      else $error("conversion without trigger");
   chk_sda_steady: assert property (
      scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("sda moved while scl high");
   chk_drive_low: assert property (
      $rose(sda_oe_out) |-> !scl_in && !$past(scl_in))
      else $error("sda driven outside scl low");
   chk_release_idle: assert property (
      scl_in [*8] |-> !sda_oe_out)
      else $error("sda held on idle bus");
   chk_pins_input: assert property (
      !sda_out && !interrupt_capable_pin_out && !convert_capable_pin_out
      && !convert_capable_pin_oe_out)
      else $error("pin driven high or convert pin driven");
endmodule
bind tcfr_core tcfr_properties #(.CONV_CYCLES(CONV_CYCLES), .CNT_W(CNT_W)) chk_i (
   .ref_clk_in(ref_clk_in), .srst_in(srst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out),
   .interrupt_capable_pin_in(interrupt_capable_pin_in),
   .interrupt_capable_pin_out(interrupt_capable_pin_out),
   .interrupt_capable_pin_oe_out(interrupt_capable_pin_oe_out),
   .convert_capable_pin_in(convert_capable_pin_in),
   .convert_capable_pin_out(convert_capable_pin_out),
   .convert_capable_pin_oe_out(convert_capable_pin_oe_out),
   .temp_code_in(temp_code_in), .conv_busy_out(conv_busy_out));
